/* File: rtl/dodr_top.v */
// object-dictionary register bank of a two-phase stepper drive
// Contract
// - control word bit 0 is switch on, 1 enable voltage, 2 quick stop, 3 enable operation, 7 fault reset, 8 halt, 10-15 reserved.
// - with bit 7 clear, x110 is shutdown, 0111 is switch on or disable operation and 1111 is enable operation.
// - with bit 7 clear, bit 1 clear means disable voltage, and bit 1 set with bit 2 clear means quick stop.
// - fault codes are 0x7500 communication, 0x3150 phase a voltage and 0x3151 phase b voltage.
// - fault codes are 0x8611 tracking error, 0x2211 overcurrent and 0x3110 overvoltage.
// - the input level object shows the six inputs in bits 0 to 5, 1 meaning a signal.
// - the output level object shows the two outputs in bits 0 and 1, 0 meaning driven.
// - the bus voltage object counts in 10 mV steps.
// - the speed reference object is read-only commanded speed in rpm, -3000 to 3000.
// - speed feedback is measured speed on the closed-loop variant, commanded speed otherwise.
// - the five servo mode 2 gains act only in closed-loop servo mode 2 with vector control.
// - the anti-vibration harmonic has amplitude 0-1000 and phases a and b 0-1024.
`timescale 1ns/1ns
`include "dodr_regs.vh"
`default_nettype none

module dodr_top (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // object access port
    input wire od_wr,
    input wire od_rd,
    input wire [15:0] od_index,
    input wire [7:0] od_subindex,
    input wire [15:0] od_wdata,
    output reg [15:0] od_rdata,
    output reg od_ack,
    output reg od_err,
    // variant and mode
    input wire closed_loop_variant,
    input wire servo2_vector_mode,
    // monitors from drive core
    input wire [15:0] speed_cmd_rpm,
    input wire [15:0] speed_meas_rpm,
    input wire [15:0] bus_voltage_10mv,
    input wire [15:0] antivib_phase_b_in,
    // pins
    input wire [5:0] digital_inputs,
    input wire [1:0] digital_outputs_driven,
    // fault causes
    input wire fault_comm,
    input wire fault_phase_a,
    input wire fault_phase_b,
    input wire fault_tracking,
    input wire fault_overcurrent,
    input wire fault_overvoltage,
    // decoded commands
    output reg cmd_shutdown,
    output reg cmd_switch_on,
    output reg cmd_enable_op,
    output reg cmd_disable_voltage,
    output reg cmd_quick_stop,
    output reg cmd_halt,
    output reg fault_reset_pulse,
    output reg fault_active,
    // gains to the loop, zero outside servo mode 2
    output reg [15:0] loop_kp,
    output reg [15:0] loop_ki,
    output reg [15:0] loop_kv1,
    output reg [15:0] loop_kv2,
    output reg [15:0] loop_kvff,
    // anti-vibration harmonic settings
    output reg [15:0] harmonic_amplitude,
    output reg [15:0] harmonic_phase_a,
    output reg [15:0] harmonic_phase_b
);

// ----------------------------------------
// storage
// ----------------------------------------
reg [15:0] servo2_position_prop_gain;
reg [15:0] servo2_integral_gain;
reg [15:0] servo2_speed_feedback_gain_one;
reg [15:0] servo2_speed_feedback_gain_two;
reg [15:0] servo2_speed_feedforward_gain;
reg [15:0] antivib_harmonic_amplitude;
reg [15:0] antivib_phase_winding_a;
reg [15:0] drive_control_word;
reg [15:0] fault_code;
// synchronised pin and fault images
wire [13:0] sync_raw;
wire [13:0] sync_q;
wire [5:0] in_sync;
wire [1:0] out_sync;
wire [5:0] flt_sync;
// read path and fault latch next values
reg [15:0] next_rdata;
reg next_err;
reg [15:0] next_fault_code;
wire servo2_hit;
wire gains_active;
wire cw_write;
wire fault_rst_edge;
// control word fields
wire decode_en;
wire cw_switch_on;
wire cw_en_volt;
wire cw_qstop_n;
wire cw_en_op;

// access decode
assign servo2_hit = (od_index == `DODR_IDX_SERVO2);
assign gains_active = closed_loop_variant & servo2_vector_mode;
assign cw_write = od_wr & (od_index == `DODR_IDX_CTRL_WORD);
// rising edge of fault reset bit, other bits ignored
assign fault_rst_edge = cw_write & od_wdata[`DODR_CW_FAULT_RST]
    & ~drive_control_word[`DODR_CW_FAULT_RST];

// ----------------------------------------
// pin and fault synchronisers
// ----------------------------------------
// raw inputs in one vector: inputs, output drive states, then fault causes
assign sync_raw = {fault_overvoltage, fault_overcurrent, fault_tracking, fault_phase_b, fault_phase_a,
    fault_comm, digital_outputs_driven, digital_inputs};

// two flops on every asynchronous bit; only the second one is read
genvar gi;
generate
    for (gi = 0; gi < 14; gi = gi + 1) begin : g_sync
        reg meta;
        reg held;
        always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                meta <= 1'b0;
                held <= 1'b0;
            end else begin
                meta <= sync_raw[gi];
                held <= meta;
            end
        end
        assign sync_q[gi] = held;
    end
endgenerate

// slices of the synchronised vector; output image inverted after the flops
assign in_sync = sync_q[5:0];
assign out_sync = ~sync_q[7:6];
assign flt_sync = sync_q[13:8];

// ----------------------------------------
// control word fields
// ----------------------------------------
// a set fault reset bit blocks every command decode except halt
assign decode_en = ~drive_control_word[`DODR_CW_FAULT_RST];
assign cw_switch_on = drive_control_word[`DODR_CW_SWITCH_ON];
assign cw_en_volt = drive_control_word[`DODR_CW_EN_VOLT];
assign cw_qstop_n = drive_control_word[`DODR_CW_QSTOP_N];
assign cw_en_op = drive_control_word[`DODR_CW_EN_OP];

// ----------------------------------------
// register writes
// ----------------------------------------
// writable objects; out-of-range harmonic amplitude and phase a writes are clamped, phase b writes are dropped
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        servo2_position_prop_gain <= `DODR_RST_KP;
        servo2_integral_gain <= `DODR_RST_KI;
        servo2_speed_feedback_gain_one <= `DODR_RST_KV1;
        servo2_speed_feedback_gain_two <= `DODR_RST_KV2;
        servo2_speed_feedforward_gain <= `DODR_RST_KVFF;
        antivib_harmonic_amplitude <= 16'h0000;
        antivib_phase_winding_a <= 16'h0000;
        drive_control_word <= 16'h0000;
    end else if (od_wr) begin
        if (servo2_hit) begin
            case (od_subindex)
                `DODR_SUB_KP: servo2_position_prop_gain <= od_wdata;
                `DODR_SUB_KI: servo2_integral_gain <= od_wdata;
                `DODR_SUB_KV1: servo2_speed_feedback_gain_one <= od_wdata;
                `DODR_SUB_KV2: servo2_speed_feedback_gain_two <= od_wdata;
                `DODR_SUB_KVFF: servo2_speed_feedforward_gain <= od_wdata;
                default: ;
            endcase
        end
        if (od_index == `DODR_IDX_AV_AMP) begin
            antivib_harmonic_amplitude <= (od_wdata > `DODR_AV_AMP_MAX) ?
                `DODR_AV_AMP_MAX : od_wdata;
        end
        if (od_index == `DODR_IDX_AV_PHASE_A) begin
            antivib_phase_winding_a <= (od_wdata > `DODR_AV_PHASE_MAX) ?
                `DODR_AV_PHASE_MAX : od_wdata;
        end
        // fault code and read-only objects take no writes
        if (cw_write) begin
            drive_control_word <= od_wdata & `DODR_CTRL_MASK;
        end
    end
end

// ----------------------------------------
// fault code latch
// ----------------------------------------
// first active cause wins; a reset clears only when no cause persists
always @* begin
    next_fault_code = fault_code;
    if (fault_rst_edge && flt_sync == 6'h00) begin
        next_fault_code = 16'h0000;
    end
    // a latched code is never overwritten by a later cause
    if (next_fault_code == 16'h0000) begin
        if (flt_sync[0]) begin
            next_fault_code = `DODR_FC_COMM;
        end else if (flt_sync[1]) begin
            next_fault_code = `DODR_FC_PHASE_A;
        end else if (flt_sync[2]) begin
            next_fault_code = `DODR_FC_PHASE_B;
        end else if (flt_sync[3]) begin
            next_fault_code = `DODR_FC_TRACK;
        end else if (flt_sync[4]) begin
            next_fault_code = `DODR_FC_OVERCUR;
        end else if (flt_sync[5]) begin
            next_fault_code = `DODR_FC_OVERVOLT;
        end
    end
end

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        fault_code <= 16'h0000;
        fault_reset_pulse <= 1'b0;
        fault_active <= 1'b0;
    end else begin
        fault_code <= next_fault_code;
        fault_reset_pulse <= fault_rst_edge;
        fault_active <= (next_fault_code != 16'h0000);
    end
end

// ----------------------------------------
// command decode
// ----------------------------------------
// decoded from the stored word; fault reset bit set blocks decode of every command except halt
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        cmd_shutdown <= 1'b0;
        cmd_switch_on <= 1'b0;
        cmd_enable_op <= 1'b0;
        cmd_disable_voltage <= 1'b0;
        cmd_quick_stop <= 1'b0;
        cmd_halt <= 1'b0;
    end else begin
        cmd_disable_voltage <= decode_en & ~cw_en_volt;
        cmd_quick_stop <= decode_en & cw_en_volt & ~cw_qstop_n;
        cmd_shutdown <= decode_en & cw_qstop_n & cw_en_volt & ~cw_switch_on;
        cmd_switch_on <= decode_en & ~cw_en_op & cw_qstop_n & cw_en_volt & cw_switch_on;
        cmd_enable_op <= decode_en & cw_en_op & cw_qstop_n & cw_en_volt & cw_switch_on;
        // halt is decoded whatever bit 7 holds
        cmd_halt <= drive_control_word[`DODR_CW_HALT];
    end
end

// ----------------------------------------
// outputs to the loop and harmonic generator
// ----------------------------------------
// gains held at zero outside servo mode 2 so the loop never runs on stale values
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        loop_kp <= 16'h0000;
        loop_ki <= 16'h0000;
        loop_kv1 <= 16'h0000;
        loop_kv2 <= 16'h0000;
        loop_kvff <= 16'h0000;
        harmonic_amplitude <= 16'h0000;
        harmonic_phase_a <= 16'h0000;
        harmonic_phase_b <= 16'h0000;
    end else begin
        loop_kp <= gains_active ? servo2_position_prop_gain : 16'h0000;
        loop_ki <= gains_active ? servo2_integral_gain : 16'h0000;
        loop_kv1 <= gains_active ? servo2_speed_feedback_gain_one : 16'h0000;
        loop_kv2 <= gains_active ? servo2_speed_feedback_gain_two : 16'h0000;
        loop_kvff <= gains_active ? servo2_speed_feedforward_gain : 16'h0000;
        harmonic_amplitude <= antivib_harmonic_amplitude;
        harmonic_phase_a <= antivib_phase_winding_a;
        // phase b follows the drive core, clamped like phase a
        harmonic_phase_b <= (antivib_phase_b_in > `DODR_AV_PHASE_MAX) ?
            `DODR_AV_PHASE_MAX : antivib_phase_b_in;
    end
end

// ----------------------------------------
// read mux
// ----------------------------------------
// unmapped index or servo subindex answers with an error
always @* begin
    next_rdata = 16'h0000;
    next_err = 1'b0;
    case (od_index)
        `DODR_IDX_SERVO2: begin
            case (od_subindex)
                `DODR_SUB_KP: next_rdata = servo2_position_prop_gain;
                `DODR_SUB_KI: next_rdata = servo2_integral_gain;
                `DODR_SUB_KV1: next_rdata = servo2_speed_feedback_gain_one;
                `DODR_SUB_KV2: next_rdata = servo2_speed_feedback_gain_two;
                `DODR_SUB_KVFF: next_rdata = servo2_speed_feedforward_gain;
                default: next_err = 1'b1;
            endcase
        end
        `DODR_IDX_SPEED_REF: next_rdata = speed_cmd_rpm;
        `DODR_IDX_SPEED_FB: next_rdata = closed_loop_variant ?
            speed_meas_rpm : speed_cmd_rpm;
        `DODR_IDX_BUS_VOLT: next_rdata = bus_voltage_10mv;
        `DODR_IDX_IN_LEVELS: next_rdata = {10'h000, in_sync};
        `DODR_IDX_OUT_LEVELS: next_rdata = {14'h0000, out_sync};
        `DODR_IDX_AV_AMP: next_rdata = antivib_harmonic_amplitude;
        `DODR_IDX_AV_PHASE_A: next_rdata = antivib_phase_winding_a;
        `DODR_IDX_AV_PHASE_B: next_rdata = harmonic_phase_b;
        `DODR_IDX_FAULT_CODE: next_rdata = fault_code;
        `DODR_IDX_CTRL_WORD: next_rdata = drive_control_word;
        default: next_err = 1'b1;
    endcase
end

// one-cycle answer to every read or write
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        od_rdata <= 16'h0000;
        od_ack <= 1'b0;
        od_err <= 1'b0;
    end else begin
        od_ack <= od_wr | od_rd;
        od_err <= (od_wr | od_rd) & next_err;
        // read data stands until the next read
        if (od_rd) begin
            od_rdata <= next_rdata;
        end
    end
end

endmodule // dodr_top

`default_nettype wire

/* File: rtl/dodr_regs.vh */
// object indices, reset values and fault codes of the drive object dictionary
`ifndef DODR_REGS_VH
`define DODR_REGS_VH
// ----------------------------------------
// object indices and subindices
// ----------------------------------------
`define DODR_IDX_SERVO2 16'h2026
`define DODR_SUB_KP 8'h01
`define DODR_SUB_KI 8'h02
`define DODR_SUB_KV1 8'h03
`define DODR_SUB_KV2 8'h04
`define DODR_SUB_KVFF 8'h05
`define DODR_IDX_SPEED_REF 16'h2043
`define DODR_IDX_SPEED_FB 16'h2044
`define DODR_IDX_BUS_VOLT 16'h2048
`define DODR_IDX_IN_LEVELS 16'h2049
`define DODR_IDX_OUT_LEVELS 16'h204a
`define DODR_IDX_AV_AMP 16'h2060
`define DODR_IDX_AV_PHASE_A 16'h2061
`define DODR_IDX_AV_PHASE_B 16'h2062
`define DODR_IDX_FAULT_CODE 16'h603f
`define DODR_IDX_CTRL_WORD 16'h6040
// ----------------------------------------
// reset values
// ----------------------------------------
`define DODR_RST_KP 16'h07d0
`define DODR_RST_KI 16'h0064
`define DODR_RST_KV1 16'h00c8
`define DODR_RST_KV2 16'h001e
`define DODR_RST_KVFF 16'h0000
// ----------------------------------------
// ranges and masks
// ----------------------------------------
`define DODR_AV_AMP_MAX 16'h03e8
`define DODR_AV_PHASE_MAX 16'h0400
`define DODR_CTRL_MASK 16'h03ff
// ----------------------------------------
// control word bit positions
// ----------------------------------------
`define DODR_CW_SWITCH_ON 0
`define DODR_CW_EN_VOLT 1
`define DODR_CW_QSTOP_N 2
`define DODR_CW_EN_OP 3
`define DODR_CW_FAULT_RST 7
`define DODR_CW_HALT 8
// ----------------------------------------
// fault codes
// ----------------------------------------
`define DODR_FC_COMM 16'h7500
`define DODR_FC_PHASE_A 16'h3150
`define DODR_FC_PHASE_B 16'h3151
`define DODR_FC_TRACK 16'h8611
`define DODR_FC_OVERCUR 16'h2211
`define DODR_FC_OVERVOLT 16'h3110
`endif

/* File: verif/dodr_checker.sv */
// assertions on the drive object dictionary register bank
`timescale 1ns/1ns
`default_nettype none
module dodr_checker (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // object access
    input wire logic od_wr,
    // decoded commands
    input wire logic cmd_shutdown,
    input wire logic cmd_switch_on,
    input wire logic cmd_enable_op,
    input wire logic cmd_disable_voltage,
    input wire logic cmd_quick_stop,
    input wire logic cmd_halt,
    input wire logic fault_reset_pulse,
    input wire logic fault_active,
    // mode, gains and harmonic
    input wire logic closed_loop_variant,
    input wire logic servo2_vector_mode,
    input wire logic [15:0] loop_kp,
    input wire logic [15:0] loop_kvff,
    input wire logic [15:0] harmonic_amplitude,
    input wire logic [15:0] harmonic_phase_a
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // command decode and timing
    property p_cmd_excl; $onehot0({cmd_shutdown, cmd_switch_on, cmd_enable_op, cmd_disable_voltage, cmd_quick_stop});
    endproperty
    a_cmd_excl: assert property (p_cmd_excl) else $error("two commands decoded at once");
    property p_enop_cause; cmd_enable_op != $past(cmd_enable_op) |-> $past(od_wr, 2); endproperty
    a_enop_cause: assert property (p_enop_cause) else $error("enable op moved without write");
    property p_qstop_cause; cmd_quick_stop != $past(cmd_quick_stop) |-> $past(od_wr, 2); endproperty
    a_qstop_cause: assert property (p_qstop_cause) else $error("quick stop moved without write");
    property p_halt_cause; cmd_halt != $past(cmd_halt) |-> $past(od_wr, 2); endproperty
    a_halt_cause: assert property (p_halt_cause) else $error("halt moved without write");
    // fault reset pulse and fault clearing
    property p_frst_pulse; fault_reset_pulse |=> !fault_reset_pulse; endproperty
    a_frst_pulse: assert property (p_frst_pulse) else $error("fault reset pulse too long");
    property p_frst_cause; fault_reset_pulse |-> $past(od_wr) || $past(od_wr, 2); endproperty
    a_frst_cause: assert property (p_frst_cause) else $error("fault reset without write");
    property p_fault_clear;
        $fell(fault_active) |-> fault_reset_pulse || $past(fault_reset_pulse) || $past(fault_reset_pulse, 2);
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault cleared without reset");
    // gains only in closed-loop servo mode 2, harmonic in range
    property p_gain_off;
        !(closed_loop_variant && servo2_vector_mode) |=> loop_kp == 16'h0000 && loop_kvff == 16'h0000;
    endproperty
    a_gain_off: assert property (p_gain_off) else $error("gain passed outside servo mode 2");
    property p_harm_range; harmonic_amplitude <= 16'h03e8 && harmonic_phase_a <= 16'h0400; endproperty
    a_harm_range: assert property (p_harm_range) else $error("harmonic setting out of range");
    // main scenarios
    c_enop: cover property (cmd_enable_op);
    c_frst: cover property (fault_reset_pulse);
    c_clear: cover property ($fell(fault_active));
endmodule // dodr_checker
bind dodr_top dodr_checker i_chk (.clk(clk), .arst_n(arst_n), .od_wr(od_wr), .cmd_shutdown(cmd_shutdown),
    .cmd_switch_on(cmd_switch_on), .cmd_enable_op(cmd_enable_op), .cmd_disable_voltage(cmd_disable_voltage),
    .cmd_quick_stop(cmd_quick_stop), .cmd_halt(cmd_halt), .fault_reset_pulse(fault_reset_pulse),
    .fault_active(fault_active), .closed_loop_variant(closed_loop_variant),
    .servo2_vector_mode(servo2_vector_mode), .loop_kp(loop_kp), .loop_kvff(loop_kvff),
    .harmonic_amplitude(harmonic_amplitude), .harmonic_phase_a(harmonic_phase_a));
`default_nettype wire

/* File: verif/dodr_master.sv */
// fieldbus master model issuing object accesses
`timescale 1ns/1ns
`default_nettype none
`include "dodr_regs.vh"
module dodr_master (
    // clock
    input wire logic clk,
    // object access port
    output logic od_wr,
    output logic od_rd,
    output logic [15:0] od_index,
    output logic [7:0] od_subindex,
    output logic [15:0] od_wdata,
    input wire logic [15:0] od_rdata,
    input wire logic od_ack,
    input wire logic od_err
);
    // idle bus at time zero
    initial begin
        od_wr = 1'b0;
        od_rd = 1'b0;
        od_index = 16'h0000;
        od_subindex = 8'h00;
        od_wdata = 16'h0000;
    end
    // one pulsed access, answer taken the cycle after
    task automatic access(input logic rd, input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] wd,
        output logic [15:0] q, output logic e, output logic ok);
        @(negedge clk);
        od_wr = ~rd;
        od_rd = rd;
        od_index = idx;
        od_subindex = sub;
        od_wdata = wd;
        @(negedge clk);
        od_wr = 1'b0;
        od_rd = 1'b0;
        od_index = ~idx;
        od_wdata = ~wd;
        ok = od_ack;
        q = od_rdata;
        e = od_err;
    endtask
    // rising edge on fault reset, whether or not a cause persists
    task automatic clear_fault(output logic ok);
        logic [15:0] q;
        logic e;
        access(1'b0, `DODR_IDX_CTRL_WORD, 8'h00, 16'h0000, q, e, ok);
        access(1'b0, `DODR_IDX_CTRL_WORD, 8'h00, 16'h0080, q, e, ok);
    endtask
endmodule // dodr_master
`default_nettype wire

/* File: verif/dodr_tb.sv */
// self-checking bench for the drive object dictionary register bank
`timescale 1ns/1ns
`default_nettype none
`include "dodr_regs.vh"
module testbench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cl_var = 1'b0;
    logic sv_mode = 1'b0;
    logic [5:0] din = 6'h00;
    logic [5:0] fault_in = 6'h00;
    logic [1:0] dout = 2'h0;
    logic [15:0] spd_cmd = 16'hf448;
    logic [15:0] spd_meas = 16'h0bb8;
    logic [15:0] bus_v = 16'h12c0;
    logic [15:0] ph_b = 16'h0155;
    logic [15:0] od_index, od_wdata, od_rdata, loop_kp, loop_kvff, h_amp, h_pa;
    logic [15:0] loop_ki, loop_kv1, loop_kv2, h_pb;
    logic [7:0] od_subindex;
    logic od_wr, od_rd, od_ack, od_err, fr_pulse, f_act;
    wire [5:0] cmds;
    int error_cnt = 0;
    int tests_run = 0;
    // 100 MHz clock
    always #5 clk = ~clk;
    dodr_master i_master (.clk(clk), .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index), .od_subindex(od_subindex),
        .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err));
    dodr_top i_dut (.clk(clk), .arst_n(arst_n), .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index),
        .od_subindex(od_subindex), .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err),
        .closed_loop_variant(cl_var), .servo2_vector_mode(sv_mode), .speed_cmd_rpm(spd_cmd),
        .speed_meas_rpm(spd_meas), .bus_voltage_10mv(bus_v), .antivib_phase_b_in(ph_b), .digital_inputs(din),
        .digital_outputs_driven(dout), .fault_comm(fault_in[0]), .fault_phase_a(fault_in[1]),
        .fault_phase_b(fault_in[2]), .fault_tracking(fault_in[3]), .fault_overcurrent(fault_in[4]),
        .fault_overvoltage(fault_in[5]), .cmd_shutdown(cmds[5]), .cmd_switch_on(cmds[4]), .cmd_enable_op(cmds[3]),
        .cmd_disable_voltage(cmds[2]), .cmd_quick_stop(cmds[1]), .cmd_halt(cmds[0]), .fault_reset_pulse(fr_pulse),
        .fault_active(f_act), .loop_kp(loop_kp), .loop_ki(loop_ki), .loop_kv1(loop_kv1), .loop_kv2(loop_kv2),
        .loop_kvff(loop_kvff), .harmonic_amplitude(h_amp), .harmonic_phase_a(h_pa), .harmonic_phase_b(h_pb));
    // comparison, access helpers and verdict
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic acc(input logic rd, input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] wd,
        output logic [15:0] q, output logic e);
        logic ok;
        i_master.access(rd, idx, sub, wd, q, e, ok);
        if (ok !== 1'b1) begin
            error_cnt++;
            final_report();
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] wd);
        logic [15:0] q;
        logic e;
        acc(1'b0, idx, sub, wd, q, e);
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] exp);
        logic [15:0] q;
        logic e;
        acc(1'b1, idx, sub, 16'h0000, q, e);
        chk(q, exp);
    endtask
    task automatic errc(input logic [15:0] idx, input logic [7:0] sub);
        logic [15:0] q;
        logic e;
        acc(1'b1, idx, sub, 16'h0000, q, e);
        chk({15'h0000, e}, 16'h0001);
    endtask
    // scenarios
    task automatic t_reset();
        logic [15:0] rv [5] = '{16'h07d0, 16'h0064, 16'h00c8, 16'h001e, 16'h0000};
        for (int i = 0; i < 5; i++) rdc(`DODR_IDX_SERVO2, 8'(i + 1), rv[i]);
        rdc(`DODR_IDX_CTRL_WORD, 8'h00, 16'h0000);
        rdc(`DODR_IDX_FAULT_CODE, 8'h00, 16'h0000);
        rdc(`DODR_IDX_OUT_LEVELS, 8'h00, 16'h0003);
        $display("t_reset done");
    endtask
    task automatic t_regs();
        wr(`DODR_IDX_AV_AMP, 8'h00, 16'h03e9);
        rdc(`DODR_IDX_AV_AMP, 8'h00, 16'h03e8);
        wr(`DODR_IDX_AV_PHASE_A, 8'h00, 16'h0401);
        rdc(`DODR_IDX_AV_PHASE_A, 8'h00, 16'h0400);
        chk(h_pa, 16'h0400);
        chk(h_amp, 16'h03e8);
        wr(`DODR_IDX_AV_PHASE_B, 8'h00, 16'h0001);
        rdc(`DODR_IDX_AV_PHASE_B, 8'h00, 16'h0155);
        chk(h_pb, 16'h0155);
        wr(`DODR_IDX_SPEED_REF, 8'h00, 16'h0001);
        rdc(`DODR_IDX_SPEED_REF, 8'h00, 16'hf448);
        errc(16'h2027, 8'h00);
        errc(`DODR_IDX_SERVO2, 8'h06);
        $display("t_regs done");
    endtask
    task automatic t_cw();
        logic [15:0] cw [10] = '{16'h0006, 16'h000e, 16'h0007, 16'h000f, 16'h0000, 16'h000d, 16'h0003,
            16'h010f, 16'h0087, 16'hfc0f};
        logic [5:0] ex [10] = '{6'h20, 6'h20, 6'h10, 6'h08, 6'h04, 6'h04, 6'h02, 6'h09, 6'h00, 6'h08};
        for (int i = 0; i < 10; i++) begin
            wr(`DODR_IDX_CTRL_WORD, 8'h00, cw[i]);
            chk({15'h0000, fr_pulse}, {15'h0000, cw[i] == 16'h0087});
            @(negedge clk);
            chk({10'h000, cmds}, {10'h000, ex[i]});
        end
        rdc(`DODR_IDX_CTRL_WORD, 8'h00, 16'h000f);
        $display("t_cw done");
    endtask
    task automatic t_pins();
        din = 6'h2d;
        dout = 2'h1;
        cl_var = 1'b1;
        repeat (4) @(negedge clk);
        rdc(`DODR_IDX_IN_LEVELS, 8'h00, 16'h002d);
        rdc(`DODR_IDX_OUT_LEVELS, 8'h00, 16'h0002);
        rdc(`DODR_IDX_SPEED_FB, 8'h00, 16'h0bb8);
        cl_var = 1'b0;
        rdc(`DODR_IDX_SPEED_FB, 8'h00, 16'hf448);
        rdc(`DODR_IDX_BUS_VOLT, 8'h00, 16'h12c0);
        $display("t_pins done");
    endtask
    task automatic t_fault();
        logic [15:0] fc [6] = '{16'h7500, 16'h3150, 16'h3151, 16'h8611, 16'h2211, 16'h3110};
        logic ok;
        for (int i = 0; i < 6; i++) begin
            fault_in = 6'(1 << i);
            repeat (5) @(negedge clk);
            rdc(`DODR_IDX_FAULT_CODE, 8'h00, fc[i]);
            i_master.clear_fault(ok);
            repeat (3) @(negedge clk);
            rdc(`DODR_IDX_FAULT_CODE, 8'h00, fc[i]);
            fault_in = 6'h00;
            repeat (4) @(negedge clk);
            i_master.clear_fault(ok);
            repeat (3) @(negedge clk);
            rdc(`DODR_IDX_FAULT_CODE, 8'h00, 16'h0000);
            chk({15'h0000, f_act}, 16'h0000);
        end
        $display("t_fault done");
    endtask
    task automatic t_gain();
        wr(`DODR_IDX_SERVO2, `DODR_SUB_KP, 16'h1234);
        wr(`DODR_IDX_SERVO2, `DODR_SUB_KVFF, 16'h0155);
        cl_var = 1'b1;
        sv_mode = 1'b1;
        repeat (2) @(negedge clk);
        chk(loop_kp, 16'h1234);
        chk(loop_kvff, 16'h0155);
        chk(loop_ki, 16'h0064);
        chk(loop_kv1, 16'h00c8);
        chk(loop_kv2, 16'h001e);
        cl_var = 1'b0;
        repeat (2) @(negedge clk);
        chk(loop_kp, 16'h0000);
        $display("t_gain done");
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        t_reset();
        t_regs();
        t_cw();
        t_pins();
        t_fault();
        t_gain();
        final_report();
    end
endmodule // testbench
`default_nettype wire
